// file: rtl/pin_sync3.sv
// Three-stage synchronizer for a pin from outside the clock domain.
// Assumes an asynchronous active-low reset; the output changes only
// once the second and third stages agree on the new level.
`timescale 1ns/1ns
module pin_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_resetn,  // Asynchronous reset, active low.
  input wire logic i_pin,     // Raw pin level.
  output logic o_level        // Synchronized, agreed level.
);
  logic meta_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      meta_ff <= i_pin;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      level_ff <= RST_VAL;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign o_level = level_ff;
endmodule

// file: rtl/powerup_init_park_sequencer.sv
// Reset, boot and mirror-park sequencer of the display controller.
// Assumes the system reset pin drives i_resetn directly, the clock runs
// before release, and PLL, flash loader and park engine report back.
`timescale 1ns/1ns
// Function
// - Flash clock, data, both selects and twenty GPIOs float during reset.
// - LED selects and mirror enable are driven low during reset.
// - After release, lock PLL, then load flash data; pins go active.
// - Interrupt line is driven high right after reset release.
// - Interrupt line goes low when initialization is done.
// - Mirror park completes within 20 ms after projector-on falls.
// - A low fast-park request starts a fast mirror park.
// - Mirror reset regulation stops about 12 ms after a normal park.
// - FPGA setup phase writes startup values; commands accepted after it.
// - Projector-on high powers up; low powers down to minimal draw.
// - Fast-park request ignores chatter up to 150 ns.
module powerup_init_park_sequencer
  import pwrseq_pkg::*;
#(
  parameter int unsigned P_FPGA_SETUP_CYC = pwrseq_pkg::FPGA_SETUP_CYC,
  parameter int unsigned P_PARK_MAX_CYC = pwrseq_pkg::PARK_MAX_CYC,
  parameter int unsigned P_REG_HOLD_CYC = pwrseq_pkg::REG_HOLD_CYC
) (
  input wire logic i_clk_sys, // Reference-derived system clock.
  input wire logic i_resetn, // System reset pin, active low.
  input wire logic i_projector_on, // Projector-on pin, high for on.
  input wire logic i_fast_park_req_n, // Fast-park request pin, active low.
  input wire logic i_pll_locked, // PLL lock indication.
  input wire logic i_flash_load_done, // Flash configuration load done.
  input wire logic i_park_done, // Park engine finished parking.
  input wire pwrseq_pkg::flash_pins_t i_flash, // Flash pin values.
  input wire pwrseq_pkg::gpio_pins_t i_gpio, // GPIO values and enables.
  input wire logic [1:0] i_led_select, // LED select from the core.
  output pwrseq_pkg::flash_pins_t o_flash, // Flash pin values.
  output logic o_flash_oe, // Flash pins output enable.
  output pwrseq_pkg::gpio_pins_t o_gpio, // GPIO values and enables.
  output logic [1:0] o_led_select, // LED select pins.
  output logic o_mirror_array_enable_n, // Mirror array enable/reset.
  output logic o_host_irq, // Initialization interrupt value.
  output logic o_host_irq_oe, // Initialization interrupt enable.
  output logic o_flash_load_en, // Flash loader may run.
  output logic o_fpga_setup, // FPGA startup writes in progress.
  output logic o_cmd_accept, // Control commands are accepted.
  output logic o_park_req, // Normal park request to engine.
  output logic o_fast_park, // Fast park request to engine.
  output logic o_reg_enable, // Mirror reset voltage regulation.
  output logic o_low_power, // Powered down to minimal draw.
  output pwrseq_pkg::seq_state_t o_state // Sequencer state.
);
  import pwrseq_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic projector_on_s;
  logic park_n_s;
  logic park_n_ff;
  logic [FILT_W-1:0] filt_cnt_ff;
  logic park_n_q_ff;
  logic fast_park_evt;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [TIMER_W-1:0] timer_ff;
  logic active_ff;
  flash_pins_t flash_ff;
  gpio_pins_t gpio_ff;
  logic [1:0] led_ff;
  logic mirror_en_n_ff;
  logic irq_ff;
  logic irq_oe_ff;
  logic reg_en_ff;

  function automatic logic timer_hit(input logic [TIMER_W-1:0] t,
                                     input int unsigned lim);
    return t >= TIMER_W'(lim - 1);
  endfunction

  // Release is synchronized; assertion stays asynchronous so that the
  // pins let go at once even without a clock.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_ff <= SYNC_RST_VAL_LOW;
      rst_sync_ff <= SYNC_RST_VAL_LOW;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  pin_sync3 #(.RST_VAL(1'b0)) u_sync_proj (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_projector_on),
    .o_level(projector_on_s)
  );

  pin_sync3 #(.RST_VAL(PARK_REQ_N_RST)) u_sync_park (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_fast_park_req_n),
    .o_level(park_n_s)
  );

  // A level must hold for the filter time before it is believed; the
  // cost is that a real request is seen 150 ns late.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      park_n_ff <= PARK_REQ_N_RST;
      filt_cnt_ff <= '0;
    end else if (park_n_s == park_n_ff) begin
      filt_cnt_ff <= '0;
    end else if (filt_cnt_ff >= FILT_W'(PARK_FILT_CYC - 1)) begin
      park_n_ff <= park_n_s;
      filt_cnt_ff <= '0;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      park_n_q_ff <= PARK_REQ_N_RST;
    end else begin
      park_n_q_ff <= park_n_ff;
    end
  end

  assign fast_park_evt = park_n_q_ff && !park_n_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (rst_sync_ff) begin
          nxt_state = ST_PLL_LOCK;
        end
      end
      ST_PLL_LOCK: begin
        if (i_pll_locked) begin
          nxt_state = ST_FLASH_LOAD;
        end
      end
      ST_FLASH_LOAD: begin
        if (i_flash_load_done) begin
          nxt_state = ST_FPGA_SETUP;
        end
      end
      ST_FPGA_SETUP: begin
        if (timer_hit(timer_ff, P_FPGA_SETUP_CYC)) begin
          nxt_state = ST_READY;
        end
      end
      ST_READY: begin
        if (!projector_on_s) begin
          nxt_state = ST_NORM_PARK;
        end
      end
      ST_NORM_PARK: begin
        if (i_park_done || timer_hit(timer_ff, P_PARK_MAX_CYC)) begin
          nxt_state = ST_REG_HOLD;
        end
      end
      ST_REG_HOLD: begin
        if (timer_hit(timer_ff, P_REG_HOLD_CYC)) begin
          nxt_state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (projector_on_s && park_n_ff) begin
          nxt_state = ST_PLL_LOCK;
        end
      end
      ST_FAST_PARK: begin
        if (i_park_done || timer_hit(timer_ff, FAST_PARK_CYC)) begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_RESET;
    endcase
    // Fast park overrides everything once the core is running.
    if (fast_park_evt && state_ff != ST_RESET && state_ff != ST_OFF) begin
      nxt_state = ST_FAST_PARK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // The timer restarts on every state change and saturates.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_ff <= '0;
    end else if (nxt_state != state_ff) begin
      timer_ff <= '0;
    end else if (timer_ff != {TIMER_W{1'b1}}) begin
      timer_ff <= timer_ff + 1'b1;
    end
  end

  // Pins are released on the synchronized edge, then stay active.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      active_ff <= 1'b0;
      flash_ff <= '0;
      gpio_ff <= '0;
    end else begin
      active_ff <= rst_sync_ff;
      flash_ff <= i_flash;
      gpio_ff.out <= i_gpio.out;
      gpio_ff.oe <= rst_sync_ff ? i_gpio.oe : '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      led_ff <= '0;
      mirror_en_n_ff <= 1'b0;
    end else begin
      led_ff <= (nxt_state == ST_READY) ? i_led_select : 2'h0;
      mirror_en_n_ff <= (nxt_state == ST_FPGA_SETUP) ||
                        (nxt_state == ST_READY) ||
                        (nxt_state == ST_NORM_PARK) ||
                        (nxt_state == ST_FAST_PARK);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      irq_oe_ff <= rst_sync_ff;
      irq_ff <= (nxt_state == ST_PLL_LOCK) ||
                (nxt_state == ST_FLASH_LOAD) ||
                (nxt_state == ST_FPGA_SETUP);
    end
  end

  // Regulation runs from flash load through park and the hold that follows.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_en_ff <= 1'b0;
    end else begin
      reg_en_ff <= (nxt_state != ST_RESET) && (nxt_state != ST_OFF) &&
                   (nxt_state != ST_PLL_LOCK);
    end
  end

  assign o_flash = flash_ff;
  assign o_flash_oe = active_ff;
  assign o_gpio = gpio_ff;
  assign o_led_select = led_ff;
  assign o_mirror_array_enable_n = mirror_en_n_ff;
  assign o_host_irq = irq_ff;
  assign o_host_irq_oe = irq_oe_ff;
  assign o_flash_load_en = (state_ff == ST_FLASH_LOAD);
  assign o_fpga_setup = (state_ff == ST_FPGA_SETUP);
  assign o_cmd_accept = (state_ff == ST_READY);
  assign o_park_req = (state_ff == ST_NORM_PARK);
  assign o_fast_park = (state_ff == ST_FAST_PARK);
  assign o_reg_enable = reg_en_ff;
  assign o_low_power = (state_ff == ST_OFF);
  assign o_state = state_ff;
endmodule

// file: rtl/pwrseq_pkg.sv
// Package for the power-up, initialization and park sequencer.
// Assumes one system clock of 125 MHz; all counts are in its cycles.
package pwrseq_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // Least time: round up to whole cycles, never below one.
  function automatic int unsigned cyc_least(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down to whole cycles, never below one.
  function automatic int unsigned cyc_most(input int unsigned t_ns);
    int unsigned c;
    c = t_ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned PARK_FILT_NS = 150;
  localparam int unsigned FPGA_SETUP_US = 2750;
  localparam int unsigned PARK_MAX_MS = 20;
  localparam int unsigned REG_HOLD_MS = 12;
  localparam int unsigned FAST_PARK_US = 32;

  localparam int unsigned PARK_FILT_CYC = cyc_least(PARK_FILT_NS);
  localparam int unsigned FPGA_SETUP_CYC = cyc_least(FPGA_SETUP_US * 1000);
  localparam int unsigned PARK_MAX_CYC = cyc_most(PARK_MAX_MS * 1000000);
  localparam int unsigned REG_HOLD_CYC = cyc_least(REG_HOLD_MS * 1000000);
  localparam int unsigned FAST_PARK_CYC = cyc_most(FAST_PARK_US * 1000);

  localparam int TIMER_W = 22;
  localparam int FILT_W = 5;
  localparam int GPIO_W = 20;

  // Values of state after reset.
  localparam logic SYNC_RST_VAL_LOW = 1'b0;
  localparam logic PARK_REQ_N_RST = 1'b1;

  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_PLL_LOCK   = 4'h1,
    ST_FLASH_LOAD = 4'h2,
    ST_FPGA_SETUP = 4'h3,
    ST_READY      = 4'h4,
    ST_NORM_PARK  = 4'h5,
    ST_REG_HOLD   = 4'h6,
    ST_OFF        = 4'h7,
    ST_FAST_PARK  = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic sclk;
    logic data_out;
    logic cs0_n;
    logic cs1_n;
  } flash_pins_t;

  typedef struct packed {
    logic [GPIO_W-1:0] out;
    logic [GPIO_W-1:0] oe;
  } gpio_pins_t;

endpackage

// file: tb/powerup_init_park_sequencer_bench.sv
// Bench for the power-up, boot and park sequencer.
// Assumes the partner model stands in for monitor, PLL and engines.
`timescale 1ns/1ns
module powerup_init_park_sequencer_bench;
  import pwrseq_pkg::*;
  localparam int unsigned SETUP = 20;
  localparam int unsigned PARK = 40;
  localparam int unsigned HOLD = 30;
  logic clk = 1'b0;
  logic resetn, pll_locked, load_done, park_done;
  logic power_good = 1'b0;
  logic slow = 1'b0;
  logic projector_on = 1'b1;
  logic park_n = 1'b1;
  flash_pins_t flash_in = 4'ha;
  flash_pins_t flash_out;
  gpio_pins_t gpio_in = 40'h5a5a5fffff;
  gpio_pins_t gpio_out;
  logic [1:0] led_in = 2'h2;
  logic [1:0] led_out;
  logic flash_oe, mirror_n, irq, irq_oe, load_en, fpga_setup, cmd_accept;
  logic park_req, fast_park, reg_en, low_power;
  seq_state_t state;
  int bad_count = 0;
  int comparisons = 0;
  powerup_init_park_sequencer #(.P_FPGA_SETUP_CYC(SETUP),
    .P_PARK_MAX_CYC(PARK), .P_REG_HOLD_CYC(HOLD)
  ) powerup_init_park_sequencer_inst (.i_clk_sys(clk), .i_resetn(resetn),
    .i_projector_on(projector_on), .i_fast_park_req_n(park_n),
    .i_pll_locked(pll_locked), .i_flash_load_done(load_done),
    .i_park_done(park_done), .i_flash(flash_in), .i_gpio(gpio_in),
    .i_led_select(led_in), .o_flash(flash_out), .o_flash_oe(flash_oe),
    .o_gpio(gpio_out), .o_led_select(led_out),
    .o_mirror_array_enable_n(mirror_n), .o_host_irq(irq),
    .o_host_irq_oe(irq_oe), .o_flash_load_en(load_en),
    .o_fpga_setup(fpga_setup), .o_cmd_accept(cmd_accept),
    .o_park_req(park_req), .o_fast_park(fast_park), .o_reg_enable(reg_en),
    .o_low_power(low_power), .o_state(state));
  pwrseq_partner pwrseq_partner_inst (.i_clk_sys(clk),
    .i_power_good(power_good), .i_park_pin_n(park_n), .i_slow(slow),
    .i_flash_load_en(load_en), .i_park_req(park_req),
    .i_fast_park(fast_park), .o_resetn(resetn), .o_pll_locked(pll_locked),
    .o_flash_load_done(load_done), .o_park_done(park_done));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_state(input seq_state_t s, input int lim);
    int i;
    i = 0;
    while (state !== s && i < lim) begin
      tick(1);
      i++;
    end
    check(state, s);
  endtask
  task automatic dwell(input seq_state_t s, output int n);
    n = 0;
    while (state === s && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic boot();
    int n;
    power_good = 1'b0;
    tick(4);
    check({flash_oe, gpio_out.oe}, 21'h0);
    check({led_out, mirror_n}, 3'h0);
    power_good = 1'b1;
    wait_state(ST_PLL_LOCK, 20);
    check({irq, irq_oe, gpio_out}, {2'h3, gpio_in});
    wait_state(ST_FLASH_LOAD, 20);
    check({load_en, reg_en, irq}, 3'h7);
    wait_state(ST_FPGA_SETUP, 20);
    check({load_en, fpga_setup, irq, cmd_accept, mirror_n}, 5'h0d);
    dwell(ST_FPGA_SETUP, n);
    check(n, SETUP);
    check({state, irq, cmd_accept, led_out, mirror_n, flash_out},
      {ST_READY, 2'h1, led_in, 1'b1, flash_in});
  endtask
  task automatic norm_park(input logic s);
    int n;
    slow = s;
    projector_on = 1'b0;
    wait_state(ST_NORM_PARK, 8);
    check({park_req, led_out}, 3'h4);
    check({reg_en, mirror_n}, 2'h3);
    dwell(ST_NORM_PARK, n);
    check((n <= PARK) && (!s || n == PARK), 1'b1);
    check({park_req, reg_en, mirror_n}, 3'h2);
    dwell(ST_REG_HOLD, n);
    check(n, HOLD);
    check({reg_en, low_power, mirror_n}, 3'h2);
    slow = 1'b0;
    projector_on = 1'b1;
    wait_state(ST_READY, 100);
  endtask
  task automatic fast_park_run(input logic s);
    int n;
    slow = s;
    park_n = 1'b0;
    tick(10);
    park_n = 1'b1;
    tick(40);
    check(state, ST_READY);
    park_n = 1'b0;
    wait_state(ST_FAST_PARK, 40);
    check(fast_park, 1'b1);
    dwell(ST_FAST_PARK, n);
    check(s ? n == FAST_PARK_CYC : n < 8, 1'b1);
    wait_state(ST_OFF, 10);
    check({low_power, reg_en, mirror_n}, 3'h4);
    slow = 1'b0;
    park_n = 1'b1;
    wait_state(ST_READY, 100);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The whole run needs about four and a half thousand cycles, most of them spent
  // in the fast park whose engine never answers.
  initial begin
    repeat (12000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    boot();
    norm_park(1'b0);
    norm_park(1'b1);
    fast_park_run(1'b0);
    fast_park_run(1'b1);
    boot();
    end_of_test();
  end
endmodule

// file: tb/powerup_init_park_sequencer_properties.sv
// Checker for the power-up, boot and park sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/1ns
module pwrseq_checker
  import pwrseq_pkg::*;
#(
  parameter int unsigned P_PARK_MAX_CYC = 2500000
) (
  input wire logic i_clk_sys, // Clock.
  input wire logic i_resetn, // Reset.
  input wire logic i_projector_on, // On pin.
  input wire logic i_fast_park_req_n, // Park pin.
  input wire pwrseq_pkg::gpio_pins_t o_gpio, // GPIO.
  input wire logic o_flash_oe, // Flash enable.
  input wire logic [1:0] o_led_select, // LEDs.
  input wire logic o_mirror_array_enable_n, // Mirror.
  input wire logic o_host_irq, // Interrupt.
  input wire logic o_host_irq_oe, // Interrupt enable.
  input wire logic o_fpga_setup, // Setup.
  input wire logic o_cmd_accept, // Commands.
  input wire logic o_park_req, // Park.
  input wire logic o_fast_park, // Fast park.
  input wire logic o_reg_enable, // Regulation.
  input wire logic o_low_power, // Off.
  input wire pwrseq_pkg::seq_state_t o_state // State.
);
  int unsigned park_cnt_ff;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      park_cnt_ff <= 0;
    end else begin
      park_cnt_ff <= o_park_req ? park_cnt_ff + 1 : 0;
    end
  end
  sequence s_proj_off;
    o_state == ST_READY && $fell(i_projector_on);
  endsequence
  // The pin must stay low well past the filter before a park is owed.
  sequence s_pin_low;
    $fell(i_fast_park_req_n) && o_state == ST_READY ##1
    (!i_fast_park_req_n)[*8] ##1 (!i_fast_park_req_n)[*8] ##1
    (!i_fast_park_req_n)[*8];
  endsequence
  a_reset_quiet: assert property ($rose(i_resetn) |->
    !o_flash_oe && o_gpio.oe == '0 && o_led_select == 2'h0 &&
    !o_mirror_array_enable_n && !o_host_irq_oe)
    else $error("outputs active at reset release");
  a_irq_boot: assert property ($rose(o_host_irq_oe) |->
    o_host_irq && o_flash_oe && o_state == ST_PLL_LOCK)
    else $error("interrupt not high at boot start");
  a_pll_first: assert property (o_state == ST_FLASH_LOAD |->
    $past(o_state) inside {ST_PLL_LOCK, ST_FLASH_LOAD})
    else $error("flash load before PLL lock");
  a_irq_done: assert property (o_state == ST_READY |->
    !o_host_irq && o_host_irq_oe && o_cmd_accept)
    else $error("interrupt not low when ready");
  a_setup_busy: assert property (o_fpga_setup |->
    o_host_irq && !o_cmd_accept && o_mirror_array_enable_n)
    else $error("commands taken during setup");
  a_park_start: assert property (s_proj_off |->
    ##[1:6] o_park_req && o_led_select == 2'h0)
    else $error("normal park did not start");
  a_park_ceiling: assert property (o_park_req |->
    park_cnt_ff < P_PARK_MAX_CYC)
    else $error("normal park overran its limit");
  a_reg_stop: assert property ($rose(o_low_power) |->
    !o_reg_enable && !o_mirror_array_enable_n)
    else $error("regulation still on when off");
  a_fast_park: assert property (s_pin_low |-> ##[0:8] o_fast_park)
    else $error("fast park did not start");
endmodule
bind powerup_init_park_sequencer pwrseq_checker #(
  .P_PARK_MAX_CYC(P_PARK_MAX_CYC)
) pwrseq_checker_inst (.i_clk_sys, .i_resetn, .i_projector_on,
  .i_fast_park_req_n, .o_gpio, .o_flash_oe, .o_led_select,
  .o_mirror_array_enable_n, .o_host_irq, .o_host_irq_oe, .o_fpga_setup,
  .o_cmd_accept, .o_park_req, .o_fast_park, .o_reg_enable, .o_low_power,
  .o_state);

// file: tb/pwrseq_partner.sv
// Model of the power monitor, PLL, flash loader and park engine.
// Assumes the bench sets supplies, park pin and park engine speed.
`timescale 1ns/1ns
module pwrseq_partner #(
  parameter int unsigned RST_CYC = 4
) (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_power_good, // Supplies within range.
  input wire logic i_park_pin_n, // Fast-park pin level.
  input wire logic i_slow, // Park engine never answers.
  input wire logic i_flash_load_en, // Loader may run.
  input wire logic i_park_req, // Normal park request.
  input wire logic i_fast_park, // Fast park request.
  output logic o_resetn, // Reset pin, active low.
  output logic o_pll_locked, // PLL lock.
  output logic o_flash_load_done, // Flash load done.
  output logic o_park_done // Park engine done.
);
  int unsigned up_cnt_ff = 0;
  int unsigned park_cnt_ff = 0;
  logic rst_ff = 1'b0;
  logic lock_ff = 1'b0;
  logic load_ff = 1'b0;
  logic done_ff = 1'b0;
  assign o_resetn = rst_ff;
  assign o_pll_locked = lock_ff;
  assign o_flash_load_done = load_ff;
  assign o_park_done = done_ff;
  // A park pin falling after release must not pull reset back down.
  always_ff @(posedge i_clk_sys) begin
    if (!i_power_good || !(rst_ff || i_park_pin_n)) begin
      up_cnt_ff <= 0;
    end else if (up_cnt_ff < 1000) begin
      up_cnt_ff <= up_cnt_ff + 1;
    end
    rst_ff <= i_power_good && up_cnt_ff >= RST_CYC;
    lock_ff <= rst_ff && up_cnt_ff >= 2 * RST_CYC;
    load_ff <= i_flash_load_en;
  end
  always_ff @(posedge i_clk_sys) begin
    park_cnt_ff <= (i_park_req || i_fast_park) ? park_cnt_ff + 1 : 0;
    done_ff <= (i_park_req || i_fast_park) && !i_slow && park_cnt_ff >= 3;
  end
endmodule
